/* File: hw/siau_pkg.sv */
package siau_pkg;

	localparam int DATA_W     = 16;
	localparam int REG_ADDR_W = 4;
	localparam int REG_DEPTH  = 16;
	localparam int WB_ADR_W   = 8;
	localparam int WB_DAT_W   = 32;
	localparam int IRQ_W      = 3;

	// index register: a divide into it writes the quotient only
	localparam logic [REG_ADDR_W-1:0] REG_INDEX_K = 4'hF;

	localparam logic [WB_ADR_W-1:0] ADDR_CMD      = 8'h00;
	localparam logic [WB_ADR_W-1:0] ADDR_STATUS   = 8'h04;
	localparam logic [WB_ADR_W-1:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [WB_ADR_W-1:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [1:0]          REGFILE_PAGE  = 2'h1;
	localparam int                  REGFILE_IDX_LSB = 2;
	localparam int                  PAGE_LSB        = 6;

	localparam int CMD_OP_LSB     = 0;
	localparam int CMD_OP_W       = 3;
	localparam int CMD_SRCA_LSB   = 4;
	localparam int CMD_SRCB_LSB   = 8;
	localparam int CMD_DST_LSB    = 12;
	localparam int CMD_ENABLE_BIT = 16;

	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_OUT_BIT   = 1;
	localparam int carry_flag_bit = 2;
	localparam int error_flag_bit = 3;

	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_OUT_BIT  = 1;
	localparam int IRQ_ERR_BIT  = 2;

	localparam logic [2*DATA_W-1:0] SAT_MAX32 = 32'h7FFFFFFF;
	localparam logic [2*DATA_W-1:0] SAT_MIN32 = 32'h80000000;
	localparam logic [DATA_W-1:0]   MIN16     = 16'h8000;
	localparam logic [DATA_W-1:0]   NEG_ONE16 = 16'hFFFF;
	localparam logic [DATA_W-1:0]   ZERO16    = 16'h0000;
	localparam logic [DATA_W-1:0]   ONE16     = 16'h0001;

	typedef enum logic [2:0] {
		OP_DIV    = 3'h0,
		OP_DADD   = 3'h1,
		OP_DSUB   = 3'h2,
		OP_ADDC   = 3'h3,
		OP_SUBC   = 3'h4,
		OP_CLRC   = 3'h5,
		OP_CLRERR = 3'h6,
		OP_NONE   = 3'h7
	} siau_op_t;

	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_RA0  = 8'h02,
		S_RA1  = 8'h04,
		S_RB0  = 8'h08,
		S_RB1  = 8'h10,
		S_CALC = 8'h20,
		S_WR0  = 8'h40,
		S_WR1  = 8'h80
	} siau_state_t;

endpackage

/* File: hw/siau_regfile.sv */
`timescale 1ns/1ps
module siau_regfile #(
	parameter int WIDTH  = 16,
	parameter int DEPTH  = 16,
	parameter int ADDR_W = 4
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [WIDTH-1:0]  wdata,
	output logic      [WIDTH-1:0]  rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// read data registered; a write does not bypass to the same cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem[addr];
		end
	end

endmodule

/* File: hw/siau_arith.sv */
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module siau_arith
	import siau_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [WB_DAT_W-1:0] wb_dat_i,
	output logic      [WB_DAT_W-1:0] wb_dat_o,
	output logic                     wb_ack_o,
	output logic                     irq,
	output logic                     resultOut,
	output logic                     instructionErrorFlag,
	output logic                     carryFlag
);

	siau_state_t           state;
	siau_op_t              cmdOp;
	logic [REG_ADDR_W-1:0] cmdA;
	logic [REG_ADDR_W-1:0] cmdB;
	logic [REG_ADDR_W-1:0] cmdDst;
	logic [DATA_W-1:0]     aLo;
	logic [DATA_W-1:0]     aHi;
	logic [DATA_W-1:0]     bLo;
	logic [DATA_W-1:0]     resLo;
	logic [DATA_W-1:0]     resHi;
	logic                  wrLo;
	logic                  wrHi;
	logic                  rdPend;
	logic [IRQ_W-1:0]      irqStat;
	logic [IRQ_W-1:0]      irqMask;

	logic                  busy;
	logic                  isMem;
	logic                  wbReq;
	logic                  memGrant;
	logic                  ctrlHit;
	logic                  cmdWr;
	logic                  cmdEnable;
	siau_op_t              wrOp;
	logic                  memWe;
	logic [REG_ADDR_W-1:0] memAddr;
	logic [DATA_W-1:0]     memWdata;
	logic [DATA_W-1:0]     memRdata;
	logic [WB_DAT_W-1:0]   ctrlRead;
	logic                  doneEvt;
	logic [IRQ_W-1:0]      setBits;
	logic [IRQ_W-1:0]      clrBits;

	logic [DATA_W-1:0]     next_resLo;
	logic [DATA_W-1:0]     next_resHi;
	logic                  next_out;
	logic                  next_carry;
	logic                  next_err;
	logic                  next_wrLo;
	logic                  next_wrHi;

	assign busy      = (state != S_IDLE);
	assign isMem     = (wb_adr_i[PAGE_LSB +: 2] == REGFILE_PAGE);
	assign wbReq     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~rdPend;
	assign memGrant  = wbReq & isMem & ~busy;
	assign ctrlHit   = wbReq & ~isMem;
	// a command arriving mid-operation is acked and dropped
	assign cmdWr     = ctrlHit & wb_we_i & (wb_adr_i == ADDR_CMD) & ~busy & (&wb_sel_i[2:0]);
	assign cmdEnable = wb_dat_i[CMD_ENABLE_BIT];
	assign wrOp      = siau_op_t'(wb_dat_i[CMD_OP_LSB +: CMD_OP_W]);

	// register file port: sequencer owns it while busy, the bus waits
	always_comb begin
		memWe    = 1'b0;
		memAddr  = wb_adr_i[REGFILE_IDX_LSB +: REG_ADDR_W];
		memWdata = wb_dat_i[DATA_W-1:0];
		unique case (state)
			S_IDLE: begin
				memWe = memGrant & wb_we_i & (&wb_sel_i[1:0]);
			end
			S_RA0: begin
				memAddr = cmdA;
			end
			S_RA1: begin
				memAddr = REG_ADDR_W'(cmdA + 1'b1);
			end
			S_RB0: begin
				memAddr = cmdB;
			end
			S_RB1: begin
				memAddr = REG_ADDR_W'(cmdB + 1'b1);
			end
			S_CALC: begin
				memAddr = cmdB;
			end
			S_WR0: begin
				memAddr  = cmdDst;
				memWdata = resLo;
				memWe    = wrLo;
			end
			S_WR1: begin
				memAddr  = REG_ADDR_W'(cmdDst + 1'b1);
				memWdata = resHi;
				memWe    = wrHi;
			end
		endcase
	end

	siau_regfile #(
		.WIDTH  (DATA_W),
		.DEPTH  (REG_DEPTH),
		.ADDR_W (REG_ADDR_W)
	) u_regfile (
		.mclk  (mclk),
		.rst_n (rst_n),
		.we    (memWe),
		.addr  (memAddr),
		.wdata (memWdata),
		.rdata (memRdata)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (cmdWr && cmdEnable && (wrOp inside {OP_DIV, OP_DADD, OP_DSUB,
							OP_ADDC, OP_SUBC})) begin
						state <= S_RA0;
					end
				end
				S_RA0:  state <= S_RA1;
				S_RA1:  state <= S_RB0;
				S_RB0:  state <= S_RB1;
				S_RB1:  state <= S_CALC;
				S_CALC: state <= S_WR0;
				S_WR0:  state <= S_WR1;
				S_WR1:  state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmdOp  <= OP_NONE;
			cmdA   <= '0;
			cmdB   <= '0;
			cmdDst <= '0;
		end else if (cmdWr) begin
			cmdOp  <= wrOp;
			cmdA   <= wb_dat_i[CMD_SRCA_LSB +: REG_ADDR_W];
			cmdB   <= wb_dat_i[CMD_SRCB_LSB +: REG_ADDR_W];
			cmdDst <= wb_dat_i[CMD_DST_LSB +: REG_ADDR_W];
		end
	end

	// read data lags the address by one state
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			aLo <= '0;
			aHi <= '0;
			bLo <= '0;
		end else begin
			if (state == S_RA1) begin
				aLo <= memRdata;
			end
			if (state == S_RB0) begin
				aHi <= memRdata;
			end
			if (state == S_RB1) begin
				bLo <= memRdata;
			end
		end
	end

	// datapath; in S_CALC memRdata holds the upper half of operand B
	always_comb begin
		logic signed [DATA_W-1:0]     divA;
		logic signed [DATA_W-1:0]     divB;
		logic [2*DATA_W:0]            dSum;
		logic [DATA_W:0]              uSum;
		logic [DATA_W+1:0]            sSum;
		logic [DATA_W+1:0]            cIn;
		divA       = aLo;
		divB       = (bLo == ZERO16) ? ONE16 : bLo;
		dSum       = '0;
		uSum       = '0;
		sSum       = '0;
		cIn        = {{(DATA_W+1){1'b0}}, carryFlag};
		next_resLo = ZERO16;
		next_resHi = ZERO16;
		next_out   = 1'b0;
		next_carry = carryFlag;
		next_err   = 1'b0;
		next_wrLo  = 1'b0;
		next_wrHi  = 1'b0;
		unique case (cmdOp)
			OP_DIV: begin
				if (bLo == ZERO16) begin
					next_err = 1'b1;
				end else begin
					next_out  = 1'b1;
					next_wrLo = 1'b1;
					next_wrHi = (cmdDst != REG_INDEX_K);
					if (aLo == MIN16 && bLo == NEG_ONE16) begin
						next_resLo = MIN16;
						next_resHi = ZERO16;
					end else begin
						next_resLo = DATA_W'(divA / divB);
						next_resHi = DATA_W'(divA % divB);
					end
				end
			end
			OP_DADD, OP_DSUB: begin
				if (cmdOp == OP_DADD) begin
					dSum = {aHi[DATA_W-1], aHi, aLo} + {memRdata[DATA_W-1], memRdata, bLo};
				end else begin
					dSum = {aHi[DATA_W-1], aHi, aLo} - {memRdata[DATA_W-1], memRdata, bLo};
				end
				next_wrLo = 1'b1;
				next_wrHi = 1'b1;
				// sign of 33-bit true result picks the clamp direction
				if (dSum[2*DATA_W] != dSum[2*DATA_W-1]) begin
					next_out = 1'b1;
					{next_resHi, next_resLo} = dSum[2*DATA_W] ? SAT_MIN32 : SAT_MAX32;
				end else begin
					{next_resHi, next_resLo} = dSum[2*DATA_W-1:0];
				end
			end
			OP_ADDC: begin
				uSum = {1'b0, aLo} + {1'b0, bLo} + cIn[DATA_W:0];
				sSum = {{2{aLo[DATA_W-1]}}, aLo} + {{2{bLo[DATA_W-1]}}, bLo} + cIn;
				next_carry = uSum[DATA_W];
				next_resLo = uSum[DATA_W-1:0];
				next_out   = (sSum[DATA_W+1:DATA_W-1] != 3'b000) &&
					(sSum[DATA_W+1:DATA_W-1] != 3'b111);
				next_wrLo  = 1'b1;
			end
			OP_SUBC: begin
				uSum = {1'b0, aLo} - {1'b0, bLo} - cIn[DATA_W:0];
				sSum = {{2{aLo[DATA_W-1]}}, aLo} - {{2{bLo[DATA_W-1]}}, bLo} - cIn;
				next_carry = uSum[DATA_W];
				next_resLo = uSum[DATA_W-1:0];
				next_out   = (sSum[DATA_W+1:DATA_W-1] != 3'b000) &&
					(sSum[DATA_W+1:DATA_W-1] != 3'b111);
				next_wrLo  = 1'b1;
			end
			default: begin
				next_carry = carryFlag;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			resLo <= '0;
			resHi <= '0;
			wrLo  <= 1'b0;
			wrHi  <= 1'b0;
		end else if (state == S_CALC) begin
			resLo <= next_resLo;
			resHi <= next_resHi;
			wrLo  <= next_wrLo;
			wrHi  <= next_wrHi;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			resultOut <= 1'b0;
		end else if (state == S_CALC) begin
			resultOut <= next_out;
		end else if (cmdWr) begin
			resultOut <= 1'b0;
		end
	end

	// only a clear command touches carry outside an executed carry op
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			carryFlag <= 1'b0;
		end else if (state == S_CALC) begin
			carryFlag <= next_carry;
		end else if (cmdWr && cmdEnable && wrOp == OP_CLRC) begin
			carryFlag <= 1'b0;
		end
	end

	// sticky: success never clears it, only the explicit clear command
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			instructionErrorFlag <= 1'b0;
		end else if (state == S_CALC && next_err) begin
			instructionErrorFlag <= 1'b1;
		end else if (cmdWr && cmdEnable && wrOp == OP_CLRERR) begin
			instructionErrorFlag <= 1'b0;
		end
	end

	assign doneEvt = (state == S_WR1) ||
		(cmdWr && !(cmdEnable && (wrOp inside {OP_DIV, OP_DADD, OP_DSUB, OP_ADDC, OP_SUBC})));

	always_comb begin
		setBits               = '0;
		clrBits               = '0;
		setBits[IRQ_DONE_BIT] = doneEvt;
		setBits[IRQ_OUT_BIT]  = (state == S_CALC) & next_out;
		setBits[IRQ_ERR_BIT]  = (state == S_CALC) & next_err;
		if (ctrlHit && wb_we_i && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0]) begin
			clrBits = wb_dat_i[IRQ_W-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irqStat <= '0;
			irqMask <= '0;
			irq     <= 1'b0;
		end else begin
			// a new event outranks a clear in the same cycle
			irqStat <= (irqStat & ~clrBits) | setBits;
			if (ctrlHit && wb_we_i && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) begin
				irqMask <= wb_dat_i[IRQ_W-1:0];
			end
			irq <= |(irqStat & irqMask);
		end
	end

	always_comb begin
		ctrlRead = '0;
		unique case (wb_adr_i)
			ADDR_CMD: begin
				ctrlRead[CMD_OP_LSB +: CMD_OP_W]     = cmdOp;
				ctrlRead[CMD_SRCA_LSB +: REG_ADDR_W] = cmdA;
				ctrlRead[CMD_SRCB_LSB +: REG_ADDR_W] = cmdB;
				ctrlRead[CMD_DST_LSB +: REG_ADDR_W]  = cmdDst;
			end
			ADDR_STATUS: begin
				ctrlRead[STAT_BUSY_BIT]  = busy;
				ctrlRead[STAT_OUT_BIT]   = resultOut;
				ctrlRead[carry_flag_bit] = carryFlag;
				ctrlRead[error_flag_bit] = instructionErrorFlag;
			end
			ADDR_IRQ_STAT: ctrlRead[IRQ_W-1:0] = irqStat;
			ADDR_IRQ_MASK: ctrlRead[IRQ_W-1:0] = irqMask;
			default:       ctrlRead = '0;
		endcase
	end

	// control registers ack after one edge, register file reads after two
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			rdPend   <= 1'b0;
		end else begin
			wb_ack_o <= ctrlHit | (memGrant & wb_we_i) | rdPend;
			rdPend   <= memGrant & ~wb_we_i;
			if (rdPend) begin
				wb_dat_o <= {{(WB_DAT_W-DATA_W){1'b0}}, memRdata};
			end else begin
				wb_dat_o <= ctrlRead;
			end
		end
	end

endmodule

/* File: dv/siau_arith_monitor.sv */
`timescale 1ns/1ps
module siau_arith_monitor
	import siau_pkg::*;
(
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_we_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]          wb_sel_i,
	input wire logic [WB_DAT_W-1:0] wb_dat_i,
	input wire logic [WB_DAT_W-1:0] wb_dat_o,
	input wire logic                wb_ack_o,
	input wire logic                irq,
	input wire logic                resultOut,
	input wire logic                instructionErrorFlag,
	input wire logic                carryFlag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic       take;
	logic       cmdTake;
	logic       calcWin;
	logic [6:0] takeHist;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmdTake = take && wb_we_i && wb_adr_i == ADDR_CMD;
	// calc edge tolerated one cycle either way
	assign calcWin = takeHist[4] || takeHist[5] || takeHist[6];
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			takeHist <= 7'h00;
		end else begin
			takeHist <= {takeHist[5:0], cmdTake};
		end
	end
	a_err_sticky: assert property ($fell(instructionErrorFlag) |-> takeHist[0] &&
		$past(wb_dat_i[2:0]) == OP_CLRERR && $past(wb_dat_i[CMD_ENABLE_BIT]))
		else $error("error flag fell without clear command");
	a_err_rise: assert property ($rose(instructionErrorFlag) |-> calcWin)
		else $error("error flag rose outside calc");
	a_carry_when: assert property ($changed(carryFlag) |-> takeHist[0] || calcWin)
		else $error("carry moved outside an operation");
	a_carry_hold: assert property (cmdTake && !wb_dat_i[CMD_ENABLE_BIT] &&
		wb_dat_i[2:0] inside {OP_ADDC, OP_SUBC} |=> $stable(carryFlag) [*3])
		else $error("disabled carry op moved carry");
	a_out_off: assert property (cmdTake && !wb_dat_i[CMD_ENABLE_BIT] |=> !resultOut [*3])
		else $error("output high while disabled");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_bound: assert property (take |-> ##[1:9] wb_ack_o)
		else $error("request never acked");
	a_stat_mirror: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_STATUS |->
		wb_dat_o[3:1] == {$past(instructionErrorFlag), $past(carryFlag), $past(resultOut)})
		else $error("status bits differ from flag pins");
	a_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	cover property ($rose(instructionErrorFlag));
	cover property ($rose(carryFlag));
	cover property ($rose(resultOut));
	cover property ($rose(irq));
endmodule

bind siau_arith siau_arith_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
	.resultOut(resultOut), .instructionErrorFlag(instructionErrorFlag), .carryFlag(carryFlag));

/* File: dv/siau_arith_tb.sv */
`timescale 1ns/1ps
module siau_arith_tb
	import siau_pkg::*;
;
	logic        mclk;
	logic        rst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [3:0]  sel;
	logic [7:0]  adr;
	logic [31:0] dat;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack;
	logic        irq;
	logic        resultOut;
	logic        errFlag;
	logic        carryFlag;
	int          fails;
	int          num_checks;

	siau_arith i_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq(irq), .resultOut(resultOut), .instructionErrorFlag(errFlag), .carryFlag(carryFlag));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic final_report();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 40) begin
			fails++;
			final_report();
		end
	endtask

	task automatic setr(input logic [3:0] n, input logic [15:0] v);
		wb(1'b1, 8'h40 + {2'h0, n, 2'h0}, {16'h0, v});
	endtask

	task automatic chkr(input logic [3:0] n, input logic [15:0] e);
		wb(1'b0, 8'h40 + {2'h0, n, 2'h0}, 32'h0);
		chk(q, {16'h0, e});
	endtask

	task automatic setp(input logic [3:0] n, input logic [31:0] v);
		setr(n, v[15:0]);
		setr(n + 4'h1, v[31:16]);
	endtask

	task automatic chkp(input logic [3:0] n, input logic [31:0] e);
		chkr(n, e[15:0]);
		chkr(n + 4'h1, e[31:16]);
	endtask

	task automatic run(input siau_op_t op, input logic [3:0] a, b, c, input logic en);
		int n;
		wb(1'b1, ADDR_CMD, {15'h0, en, c, b, a, 1'b0, op});
		n = 0;
		do begin
			wb(1'b0, ADDR_STATUS, 32'h0);
			n++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 20);
		if (n >= 20) begin
			fails++;
			final_report();
		end
	endtask

	task automatic fl(input logic o, c, e);
		chk({29'h0, resultOut, carryFlag, errFlag}, {29'h0, o, c, e});
	endtask

	task automatic t_div();
		setr(4'h0, 16'd2894);
		setr(4'h1, 16'd325);
		run(OP_DIV, 4'h0, 4'h1, 4'h2, 1'b1);
		chkr(4'h2, 16'd8);
		chkr(4'h3, 16'd294);
		fl(1'b1, 1'b0, 1'b0);
		setr(4'h4, MIN16);
		setr(4'h5, NEG_ONE16);
		run(OP_DIV, 4'h4, 4'h5, 4'h6, 1'b1);
		chkp(4'h6, {16'h0, MIN16});
		setr(4'h0, 16'h1234);
		run(OP_DIV, 4'h1, 4'h5, REG_INDEX_K, 1'b1);
		chkr(REG_INDEX_K, 16'hFEBB);
		chkr(4'h0, 16'h1234);
	endtask

	task automatic t_err();
		setr(4'h8, ZERO16);
		setr(4'h9, 16'h5555);
		run(OP_DIV, 4'h1, 4'h8, 4'h9, 1'b1);
		chkr(4'h9, 16'h5555);
		fl(1'b0, 1'b0, 1'b1);
	endtask

	task automatic dw(input siau_op_t op, input logic [31:0] a, b, e, input logic o);
		setp(4'hA, a);
		setp(4'hC, b);
		run(op, 4'hA, 4'hC, 4'hE, 1'b1);
		chkp(4'hE, e);
		fl(o, 1'b0, 1'b1);
	endtask

	task automatic t_clr();
		run(OP_DADD, 4'hA, 4'hC, 4'hE, 1'b0);
		chkp(4'hE, SAT_MIN32);
		fl(1'b0, 1'b0, 1'b1);
		run(OP_CLRERR, 4'h0, 4'h0, 4'h0, 1'b0);
		fl(1'b0, 1'b0, 1'b1);
		run(OP_CLRERR, 4'h0, 4'h0, 4'h0, 1'b1);
		fl(1'b0, 1'b0, 1'b0);
	endtask

	task automatic cr(input siau_op_t op, input logic [15:0] a, b, e, input logic c, o);
		setr(4'h0, a);
		setr(4'h1, b);
		run(op, 4'h0, 4'h1, 4'h2, 1'b1);
		chkr(4'h2, e);
		fl(o, c, 1'b0);
	endtask

	task automatic t_idle();
		run(OP_ADDC, 4'h0, 4'h1, 4'h2, 1'b0);
		chkr(4'h2, NEG_ONE16);
		fl(1'b0, 1'b1, 1'b0);
		run(OP_CLRC, 4'h0, 4'h0, 4'h0, 1'b1);
		fl(1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_irq();
		wb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, ADDR_IRQ_STAT, 32'h7);
		run(OP_NONE, 4'h0, 4'h0, 4'h0, 1'b1);
		chk({31'h0, irq}, 32'h0);
		wb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(q[IRQ_DONE_BIT], 1'b1);
		wb(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_DONE_BIT);
		wb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk(q, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, ADDR_IRQ_STAT, 32'h7);
		wb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, 8'h10, 32'hFFFF);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
		run(OP_DIV, 4'h1, 4'h8, 4'h9, 1'b1);
		run(OP_DIV, 4'h0, 4'h1, 4'h2, 1'b1);
		wb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(q, 32'h7);
		chk({31'h0, irq}, 32'h1);
	endtask

	// partial lane select on a command is acked but must not act
	task automatic t_sel();
		sel <= 4'h1;
		run(OP_CLRERR, 4'h0, 4'h0, 4'h0, 1'b1);
		fl(1'b1, 1'b1, 1'b1);
		sel <= 4'hF;
		run(OP_CLRERR, 4'h0, 4'h0, 4'h0, 1'b1);
		fl(1'b0, 1'b1, 1'b0);
	endtask

	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'hF;
		adr = 8'h00;
		dat = 32'h0;
		rst_n = 1'b0;
		fails = 0;
		num_checks = 0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		fl(1'b0, 1'b0, 1'b0);
		t_div();
		t_err();
		dw(OP_DADD, 32'h000493E0, 32'h000186A0, 32'h00061A80, 1'b0);
		dw(OP_DADD, SAT_MAX32, 32'h1, SAT_MAX32, 1'b1);
		dw(OP_DSUB, 32'h00181BE0, 32'h00013880, 32'h0016E360, 1'b0);
		dw(OP_DSUB, SAT_MIN32, 32'h1, SAT_MIN32, 1'b1);
		t_clr();
		run(OP_CLRC, 4'h0, 4'h0, 4'h0, 1'b1);
		cr(OP_ADDC, 16'h7FFF, ONE16, MIN16, 1'b0, 1'b1);
		cr(OP_ADDC, NEG_ONE16, ONE16, ZERO16, 1'b1, 1'b0);
		cr(OP_ADDC, ONE16, ONE16, 16'h0003, 1'b0, 1'b0);
		cr(OP_SUBC, ZERO16, ONE16, NEG_ONE16, 1'b1, 1'b0);
		cr(OP_SUBC, 16'h0005, ONE16, 16'h0003, 1'b0, 1'b0);
		cr(OP_SUBC, MIN16, ONE16, 16'h7FFF, 1'b0, 1'b1);
		cr(OP_SUBC, ZERO16, ONE16, NEG_ONE16, 1'b1, 1'b0);
		t_idle();
		cr(OP_ADDC, MIN16, MIN16, ZERO16, 1'b1, 1'b1);
		t_irq();
		t_sel();
		final_report();
	end
endmodule
